// file: rtl/utci_pkg.sv
package utci_pkg;

  // host frame layout, first bit on the wire is bit 15
  localparam logic [4:0] FRAME_BITS        = 5'h10;
  localparam logic [1:0] CMD_RD_DATA       = 2'h0;
  localparam logic [1:0] CMD_RD_CFG        = 2'h1;
  localparam logic [1:0] CMD_WR_DATA       = 2'h2;
  localparam logic [1:0] CMD_WR_CFG        = 2'h3;
  localparam int         POS_CMD_HI        = 15;
  localparam int         POS_CMD_LO        = 14;
  localparam int         POS_RX_AVAIL      = 15;
  localparam int         POS_TX_EMPTY      = 14;
  localparam int         POS_TX_EMPTY_MASK = 13;
  localparam int         POS_RX_AVAIL_MASK = 12;
  localparam int         POS_EXTRA_MASK    = 11;
  localparam int         POS_ACT_MASK      = 10;
  localparam int         POS_TWO_STOP      = 6;
  localparam int         POS_EXTRA_EN      = 5;
  localparam int         POS_INHIBIT       = 10;
  localparam int         POS_RTS           = 9;
  localparam int         POS_EXTRA         = 8;
  localparam int         POS_ACTIVITY      = 10;

  // reset values
  localparam logic [3:0] RST_MASKS         = 4'h0;
  localparam logic       RST_TWO_STOP      = 1'b0;
  localparam logic       RST_EXTRA_EN      = 1'b0;
  localparam logic       RST_RTS           = 1'b0;

  // character shape
  localparam int         DEF_BIT_CYCLES    = 16;
  localparam int         DEF_FIFO_DEPTH    = 8;
  localparam int         WORD_BITS         = 9;
  localparam logic [3:0] DATA_BITS         = 4'h8;
  localparam logic [3:0] DATA_EXTRA_BITS   = 4'h9;
  localparam logic [3:0] DATA_LAST_IDX     = 4'h7;
  localparam logic [3:0] EXTRA_IDX         = 4'h8;
  localparam logic [3:0] STOPS_ONE         = 4'h1;
  localparam logic [3:0] STOPS_TWO         = 4'h2;

  // pin synchronisers: index and idle level of each pin
  localparam int         SYNC_COUNT        = 5;
  localparam int         IDX_SCLK          = 0;
  localparam int         IDX_CS            = 1;
  localparam int         IDX_DIN           = 2;
  localparam int         IDX_RXD           = 3;
  localparam int         IDX_SHDN          = 4;
  localparam logic [4:0] SYNC_RST          = 5'h1A;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_BITS  = 2'b10,
    TX_STOP  = 2'b11
  } utci_tx_state_type;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } utci_rx_state_type;

endpackage : utci_pkg

// file: rtl/utci_fifo.sv
module utci_fifo #(
  parameter int WIDTH = utci_pkg::WORD_BITS,
  parameter int DEPTH = utci_pkg::DEF_FIFO_DEPTH
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             wrValid,
  output logic                  wrReady,
  input  wire logic [WIDTH-1:0] wrData,
  output logic                  rdValid,
  input  wire logic             rdReady,
  output logic      [WIDTH-1:0] rdData
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_r, wrPtr_nxt;
  logic [PW-1:0]    rdPtr_r, rdPtr_nxt;
  logic [CW-1:0]    count_r, count_nxt;
  logic             doWr;
  logic             doRd;

  assign wrReady = (count_r != FULL_CNT);
  assign rdValid = (count_r != '0);
  assign rdData  = mem[rdPtr_r];
  assign doWr    = wrValid & wrReady;
  assign doRd    = rdValid & rdReady;

  always_comb begin
    wrPtr_nxt = wrPtr_r;
    rdPtr_nxt = rdPtr_r;
    count_nxt = count_r;
    if (doWr) begin
      wrPtr_nxt = (wrPtr_r == LAST_PTR) ? '0 : wrPtr_r + 1'b1;
    end
    if (doRd) begin
      rdPtr_nxt = (rdPtr_r == LAST_PTR) ? '0 : rdPtr_r + 1'b1;
    end
    if (doWr && !doRd) begin
      count_nxt = count_r + 1'b1;
    end else if (doRd && !doWr) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
    end
  end

  // storage carries no reset, only pointers define content
  always_ff @(posedge ref_clk) begin
    if (doWr) begin
      mem[wrPtr_r] <= wrData;
    end
  end

endmodule : utci_fifo

// file: rtl/utci_uart_ctrl.sv
// Operation
// - one stop bit, or two when selected
// - receiver needs only one stop bit
// - two-stop select resets 0, reads back
// - transmit-empty flag high when buffer accepts
// - inhibit set: write updates request-to-send only
// - masked transmit-empty event drives interrupt low
// - data read end clears transmit-empty source
// - clearing source leaves transmit-empty flag intact
// - every data read deasserts interrupt
// - extra-bit flag shows oldest stored word
// - extra-bit interrupt from oldest word, masked
// - receive-available holds interrupt while masked on
// - receive-available clears when buffer drained
// - shutdown: activity flag, line transition sets
// - normal: bad stop sets error, good clears
// - framing error not stored with words
// - masked activity/error flag drives interrupt
// - extra bit sent as written, none computed
// - framing error returns receiver to start search
module utci_uart_ctrl #(
  parameter int BIT_CYCLES = utci_pkg::DEF_BIT_CYCLES,
  parameter int FIFO_DEPTH = utci_pkg::DEF_FIFO_DEPTH
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic spiCsN,
  input  wire logic spiSclk,
  input  wire logic spiDin,
  output logic      spiDout,
  input  wire logic rxd,
  output logic      txd,
  output logic      rtsN,
  input  wire logic shutdownN,
  output logic      irqN
);
  localparam int            TW          = $clog2(BIT_CYCLES);
  localparam logic [TW-1:0] BIT_RELOAD  = TW'(BIT_CYCLES - 1);
  localparam logic [TW-1:0] HALF_RELOAD = TW'(BIT_CYCLES / 2 - 1);
  localparam int            WB          = utci_pkg::WORD_BITS;

  logic [utci_pkg::SYNC_COUNT-1:0] asyncIn, syncA_r, syncB_r, syncC_r;
  logic                            sclkRise, sclkFall, csFall, csRise, csN, din;
  logic                            rxLine, rxEdge, rxFall, shdn, shdnRise, shdnFall;

  assign asyncIn = {shutdownN, rxd, spiDin, spiCsN, spiSclk};

  // two stages per pin, third stage only for edge finding
  for (genvar i = 0; i < utci_pkg::SYNC_COUNT; i++) begin : g_sync
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        syncA_r[i] <= utci_pkg::SYNC_RST[i];
        syncB_r[i] <= utci_pkg::SYNC_RST[i];
        syncC_r[i] <= utci_pkg::SYNC_RST[i];
      end else begin
        syncA_r[i] <= asyncIn[i];
        syncB_r[i] <= syncA_r[i];
        syncC_r[i] <= syncB_r[i];
      end
    end
  end

  assign sclkRise = syncB_r[utci_pkg::IDX_SCLK] & ~syncC_r[utci_pkg::IDX_SCLK];
  assign sclkFall = ~syncB_r[utci_pkg::IDX_SCLK] & syncC_r[utci_pkg::IDX_SCLK];
  assign csFall   = ~syncB_r[utci_pkg::IDX_CS] & syncC_r[utci_pkg::IDX_CS];
  assign csRise   = syncB_r[utci_pkg::IDX_CS] & ~syncC_r[utci_pkg::IDX_CS];
  assign csN      = syncB_r[utci_pkg::IDX_CS];
  assign din      = syncB_r[utci_pkg::IDX_DIN];
  assign rxLine   = syncB_r[utci_pkg::IDX_RXD];
  assign rxEdge   = syncB_r[utci_pkg::IDX_RXD] ^ syncC_r[utci_pkg::IDX_RXD];
  assign rxFall   = ~syncB_r[utci_pkg::IDX_RXD] & syncC_r[utci_pkg::IDX_RXD];
  assign shdn     = ~syncB_r[utci_pkg::IDX_SHDN];
  assign shdnRise = ~syncB_r[utci_pkg::IDX_SHDN] & syncC_r[utci_pkg::IDX_SHDN];
  assign shdnFall = syncB_r[utci_pkg::IDX_SHDN] & ~syncC_r[utci_pkg::IDX_SHDN];

  // host frame, configuration and flags
  logic [4:0]    hBitCnt_r, hBitCnt_nxt;
  logic [15:0]   hShift_r, hShift_nxt;
  logic [1:0]    hCmd_r, hCmd_nxt;
  logic          dout_r, dout_nxt;
  logic [15:0]   outWord;
  logic          frameEnd, wrCfgEnd, wrDataEnd, rdDataEnd;
  logic          txEmptyMask_r, txEmptyMask_nxt, rxAvailMask_r, rxAvailMask_nxt;
  logic          extraMask_r, extraMask_nxt, actMask_r, actMask_nxt;
  logic          twoStop_r, twoStop_nxt, extraEn_r, extraEn_nxt, rts_r, rts_nxt;
  logic          txEmpty, txEmptyPrev_r, txEmptyRise, txEmptySrc_r, txEmptySrc_nxt;
  logic          actFe_r, actFe_nxt, irqN_r, irqN_nxt, irqAny, txPush;
  logic          rxValid, rxExtra, rxPush, rxReady, stopGood, stopBad;
  logic [WB-1:0] rxHead, rxWord, txPopData;
  logic          txPopValid, txPop;

  assign frameEnd  = csRise && (hBitCnt_r == utci_pkg::FRAME_BITS);
  assign wrCfgEnd  = frameEnd && (hCmd_r == utci_pkg::CMD_WR_CFG);
  assign wrDataEnd = frameEnd && (hCmd_r == utci_pkg::CMD_WR_DATA);
  assign rdDataEnd = frameEnd && (hCmd_r == utci_pkg::CMD_RD_DATA);

  assign rxExtra = rxValid & rxHead[utci_pkg::EXTRA_IDX];

  // outputs straight from flops
  assign spiDout = dout_r;
  assign irqN    = irqN_r;

  always_comb begin
    outWord = '0;
    outWord[utci_pkg::POS_RX_AVAIL] = rxValid;
    outWord[utci_pkg::POS_TX_EMPTY] = txEmpty;
    if (hCmd_r == utci_pkg::CMD_RD_CFG) begin
      outWord[utci_pkg::POS_TX_EMPTY_MASK] = txEmptyMask_r;
      outWord[utci_pkg::POS_RX_AVAIL_MASK] = rxAvailMask_r;
      outWord[utci_pkg::POS_EXTRA_MASK]    = extraMask_r;
      outWord[utci_pkg::POS_ACT_MASK]      = actMask_r;
      outWord[utci_pkg::POS_TWO_STOP]      = twoStop_r;
      outWord[utci_pkg::POS_EXTRA_EN]      = extraEn_r;
    end else if (hCmd_r == utci_pkg::CMD_RD_DATA) begin
      outWord[utci_pkg::POS_ACTIVITY] = actFe_r;
      outWord[utci_pkg::POS_EXTRA]    = rxExtra;
      outWord[7:0]                    = rxHead[7:0];
    end
  end

  always_comb begin
    hBitCnt_nxt = hBitCnt_r;
    hShift_nxt  = hShift_r;
    hCmd_nxt    = hCmd_r;
    dout_nxt    = dout_r;
    if (csFall) begin
      hBitCnt_nxt = '0;
      dout_nxt    = outWord[15];
    end else if (!csN && sclkRise && hBitCnt_r != utci_pkg::FRAME_BITS) begin
      hShift_nxt  = {hShift_r[14:0], din};
      hBitCnt_nxt = hBitCnt_r + 5'h01;
      if (hBitCnt_r == 5'h01) begin
        hCmd_nxt = {hShift_r[0], din};
      end
    end else if (!csN && sclkFall && hBitCnt_r < utci_pkg::FRAME_BITS) begin
      dout_nxt = outWord[4'hF - hBitCnt_r[3:0]];
    end
  end

  always_comb begin
    txEmptyMask_nxt = txEmptyMask_r;
    rxAvailMask_nxt = rxAvailMask_r;
    extraMask_nxt   = extraMask_r;
    actMask_nxt     = actMask_r;
    twoStop_nxt     = twoStop_r;
    extraEn_nxt     = extraEn_r;
    rts_nxt         = rts_r;
    if (wrCfgEnd) begin
      txEmptyMask_nxt = hShift_r[utci_pkg::POS_TX_EMPTY_MASK];
      rxAvailMask_nxt = hShift_r[utci_pkg::POS_RX_AVAIL_MASK];
      extraMask_nxt   = hShift_r[utci_pkg::POS_EXTRA_MASK];
      actMask_nxt     = hShift_r[utci_pkg::POS_ACT_MASK];
      twoStop_nxt     = hShift_r[utci_pkg::POS_TWO_STOP];
      extraEn_nxt     = hShift_r[utci_pkg::POS_EXTRA_EN];
    end
    if (wrDataEnd) begin
      rts_nxt = hShift_r[utci_pkg::POS_RTS];
    end
  end

  // inhibit keeps the word out of the buffer
  assign txPush = wrDataEnd && !hShift_r[utci_pkg::POS_INHIBIT];

  always_comb begin
    // read end clears, new empty event wins
    txEmptyRise    = txEmpty & ~txEmptyPrev_r;
    txEmptySrc_nxt = txEmptyRise | (txEmptySrc_r & ~rdDataEnd);
    irqAny = (txEmptyMask_r & txEmptySrc_r) | (rxAvailMask_r & rxValid)
           | (extraMask_r & rxExtra) | (actMask_r & actFe_r);
    // data read end forces interrupt off for a cycle
    irqN_nxt = rdDataEnd | ~irqAny;
  end

  always_comb begin
    actFe_nxt = actFe_r;
    // entering and leaving shutdown both clear
    if (shdnRise || shdnFall) begin
      actFe_nxt = 1'b0;
    end
    if (!shdn && stopGood) begin
      actFe_nxt = 1'b0;
    end
    // set wins; flag lives only here, never in buffer
    if ((shdn && rxEdge) || (!shdn && stopBad)) begin
      actFe_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hBitCnt_r     <= '0;
      hShift_r      <= '0;
      hCmd_r        <= utci_pkg::CMD_RD_DATA;
      dout_r        <= 1'b0;
      txEmptyMask_r <= utci_pkg::RST_MASKS[3];
      rxAvailMask_r <= utci_pkg::RST_MASKS[2];
      extraMask_r   <= utci_pkg::RST_MASKS[1];
      actMask_r     <= utci_pkg::RST_MASKS[0];
      twoStop_r     <= utci_pkg::RST_TWO_STOP;
      extraEn_r     <= utci_pkg::RST_EXTRA_EN;
      rts_r         <= utci_pkg::RST_RTS;
      txEmptyPrev_r <= 1'b1;
      txEmptySrc_r  <= 1'b0;
      actFe_r       <= 1'b0;
      irqN_r        <= 1'b1;
    end else begin
      hBitCnt_r     <= hBitCnt_nxt;
      hShift_r      <= hShift_nxt;
      hCmd_r        <= hCmd_nxt;
      dout_r        <= dout_nxt;
      txEmptyMask_r <= txEmptyMask_nxt;
      rxAvailMask_r <= rxAvailMask_nxt;
      extraMask_r   <= extraMask_nxt;
      actMask_r     <= actMask_nxt;
      twoStop_r     <= twoStop_nxt;
      extraEn_r     <= extraEn_nxt;
      rts_r         <= rts_nxt;
      txEmptyPrev_r <= txEmpty;
      txEmptySrc_r  <= txEmptySrc_nxt;
      actFe_r       <= actFe_nxt;
      irqN_r        <= irqN_nxt;
    end
  end

  // transmitter
  utci_pkg::utci_tx_state_type txState_r, txState_nxt;
  utci_pkg::utci_rx_state_type rxState_r, rxState_nxt;
  logic [TW-1:0]               txTimer_r, txTimer_nxt, rxTimer_r, rxTimer_nxt;
  logic [3:0]                  txBitIdx_r, txBitIdx_nxt, rxBitIdx_r, rxBitIdx_nxt;
  logic [WB-1:0]               txShift_r, txShift_nxt, rxShift_r, rxShift_nxt;
  logic                        txd_r, txd_nxt, rtsN_r;
  logic [3:0]                  txLastIdx, rxLastIdx, stopLast;

  assign txLastIdx = extraEn_r ? utci_pkg::EXTRA_IDX : utci_pkg::DATA_LAST_IDX;
  assign rxLastIdx = extraEn_r ? utci_pkg::EXTRA_IDX : utci_pkg::DATA_LAST_IDX;
  assign stopLast  = twoStop_r ? utci_pkg::STOPS_TWO : utci_pkg::STOPS_ONE;
  assign txd       = txd_r;
  assign rtsN      = rtsN_r;
  assign rxWord    = rxShift_r;

  // one-word buffer, flag is its free space only
  utci_fifo #(
    .WIDTH(WB),
    .DEPTH(1)
  ) i_txBuf (
    .ref_clk(ref_clk),
    .rst_n  (rst_n),
    .wrValid(txPush),
    .wrReady(txEmpty),
    .wrData (hShift_r[WB-1:0]),
    .rdValid(txPopValid),
    .rdReady(txPop),
    .rdData (txPopData)
  );

  // words leave only on data reads
  utci_fifo #(
    .WIDTH(WB),
    .DEPTH(FIFO_DEPTH)
  ) i_rxBuf (
    .ref_clk(ref_clk),
    .rst_n  (rst_n),
    .wrValid(rxPush),
    .wrReady(rxReady),
    .wrData (rxWord),
    .rdValid(rxValid),
    .rdReady(rdDataEnd),
    .rdData (rxHead)
  );

  always_comb begin
    txState_nxt  = txState_r;
    txTimer_nxt  = txTimer_r;
    txBitIdx_nxt = txBitIdx_r;
    txShift_nxt  = txShift_r;
    txd_nxt      = txd_r;
    txPop        = 1'b0;
    if (txTimer_r != '0) begin
      txTimer_nxt = txTimer_r - 1'b1;
    end
    case (txState_r)
      utci_pkg::TX_IDLE: begin
        if (txPopValid) begin
          txPop       = 1'b1;
          txShift_nxt = txPopData;
          txd_nxt     = 1'b0;
          txTimer_nxt = BIT_RELOAD;
          txState_nxt = utci_pkg::TX_START;
        end
      end
      utci_pkg::TX_START: begin
        if (txTimer_r == '0) begin
          txTimer_nxt  = BIT_RELOAD;
          txBitIdx_nxt = '0;
          txd_nxt      = txShift_r[0];
          txState_nxt  = utci_pkg::TX_BITS;
        end
      end
      utci_pkg::TX_BITS: begin
        if (txTimer_r == '0) begin
          txTimer_nxt = BIT_RELOAD;
          if (txBitIdx_r == txLastIdx) begin
            txd_nxt      = 1'b1;
            txBitIdx_nxt = utci_pkg::STOPS_ONE;
            txState_nxt  = utci_pkg::TX_STOP;
          end else begin
            txBitIdx_nxt = txBitIdx_r + 4'h1;
            txd_nxt      = txShift_r[txBitIdx_nxt];
          end
        end
      end
      utci_pkg::TX_STOP: begin
        if (txTimer_r == '0) begin
          if (txBitIdx_r != stopLast) begin
            txBitIdx_nxt = txBitIdx_r + 4'h1;
            txTimer_nxt  = BIT_RELOAD;
          end else if (txPopValid) begin
            // next word starts with no idle gap
            txPop       = 1'b1;
            txShift_nxt = txPopData;
            txd_nxt     = 1'b0;
            txTimer_nxt = BIT_RELOAD;
            txState_nxt = utci_pkg::TX_START;
          end else begin
            txState_nxt = utci_pkg::TX_IDLE;
          end
        end
      end
      default: begin
        txState_nxt = utci_pkg::TX_IDLE;
      end
    endcase
  end

  // receiver
  always_comb begin
    rxState_nxt  = rxState_r;
    rxTimer_nxt  = rxTimer_r;
    rxBitIdx_nxt = rxBitIdx_r;
    rxShift_nxt  = rxShift_r;
    rxPush       = 1'b0;
    stopGood     = 1'b0;
    stopBad      = 1'b0;
    if (rxTimer_r != '0) begin
      rxTimer_nxt = rxTimer_r - 1'b1;
    end
    case (rxState_r)
      utci_pkg::RX_IDLE: begin
        if (rxFall && !shdn) begin
          rxTimer_nxt = HALF_RELOAD;
          rxState_nxt = utci_pkg::RX_START;
        end
      end
      utci_pkg::RX_START: begin
        if (rxTimer_r == '0) begin
          if (!rxLine) begin
            rxTimer_nxt  = BIT_RELOAD;
            rxBitIdx_nxt = '0;
            rxShift_nxt  = '0;
            rxState_nxt  = utci_pkg::RX_DATA;
          end else begin
            rxState_nxt = utci_pkg::RX_IDLE;
          end
        end
      end
      utci_pkg::RX_DATA: begin
        if (rxTimer_r == '0) begin
          rxShift_nxt[rxBitIdx_r] = rxLine;
          rxTimer_nxt             = BIT_RELOAD;
          if (rxBitIdx_r == rxLastIdx) begin
            rxState_nxt = utci_pkg::RX_STOP;
          end else begin
            rxBitIdx_nxt = rxBitIdx_r + 4'h1;
          end
        end
      end
      utci_pkg::RX_STOP: begin
        if (rxTimer_r == '0) begin
          // one stop only, then hunt for start
          rxState_nxt = utci_pkg::RX_IDLE;
          if (rxLine) begin
            stopGood = 1'b1;
            // word is dropped when the buffer is full
            rxPush   = rxReady;
          end else begin
            stopBad = 1'b1;
          end
        end
      end
      default: begin
        rxState_nxt = utci_pkg::RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txState_r  <= utci_pkg::TX_IDLE;
      txTimer_r  <= '0;
      txBitIdx_r <= '0;
      txShift_r  <= '0;
      txd_r      <= 1'b1;
      rtsN_r     <= ~utci_pkg::RST_RTS;
      rxState_r  <= utci_pkg::RX_IDLE;
      rxTimer_r  <= '0;
      rxBitIdx_r <= '0;
      rxShift_r  <= '0;
    end else begin
      txState_r  <= txState_nxt;
      txTimer_r  <= txTimer_nxt;
      txBitIdx_r <= txBitIdx_nxt;
      txShift_r  <= txShift_nxt;
      txd_r      <= txd_nxt;
      rtsN_r     <= ~rts_nxt;
      rxState_r  <= rxState_nxt;
      rxTimer_r  <= rxTimer_nxt;
      rxBitIdx_r <= rxBitIdx_nxt;
      rxShift_r  <= rxShift_nxt;
    end
  end

  sequence sStopEnter;
    (txState_r == utci_pkg::TX_BITS) ##1 (txState_r == utci_pkg::TX_STOP);
  endsequence

  sequence sEmptyEvt;
    !txEmpty ##1 txEmpty;
  endsequence

  AST_STOP_HIGH: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sStopEnter |-> txd_r)
    else $error("stop bit not high");

  AST_STOP_COUNT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (txState_r == utci_pkg::TX_STOP && txState_nxt != utci_pkg::TX_STOP)
    |-> (txBitIdx_r == stopLast))
    else $error("wrong stop bit count");

  AST_INHIBIT_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wrDataEnd && hShift_r[utci_pkg::POS_INHIBIT] && txEmpty) |=> txEmpty)
    else $error("inhibited write filled buffer");

  AST_RTS_FOLLOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrDataEnd |=> (rtsN_r != $past(hShift_r[utci_pkg::POS_RTS])))
    else $error("request-to-send not updated");

  AST_EMPTY_SRC: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sEmptyEvt |=> txEmptySrc_r)
    else $error("empty event lost");

  AST_IRQ_RD_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rdDataEnd |=> irqN_r)
    else $error("interrupt kept on data read");

  AST_IRQ_SOURCES: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (irqAny && !rdDataEnd) |=> !irqN_r)
    else $error("masked source without interrupt");

  AST_FE_RESTART: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rxState_r == utci_pkg::RX_STOP && rxTimer_r == '0 && !rxLine)
    |=> (rxState_r == utci_pkg::RX_IDLE))
    else $error("receiver not back to start search");
endmodule : utci_uart_ctrl

// file: dv/utci_host_model.sv
module utci_host_model (
  input  wire logic ref_clk,
  output logic      spiCsN,
  output logic      spiSclk,
  output logic      spiDin,
  input  wire logic spiDout
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    spiCsN  = 1'h1;
    spiSclk = 1'h0;
    spiDin  = 1'h0;
  end

  // sclk stands low between frames; half period is four ref_clk cycles
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge ref_clk);
    spiCsN <= 1'h0;
    for (int i = 15; i >= 0; i--) begin
      spiDin <= tx[i];
      repeat (4) @(posedge ref_clk);
      rx[i] = spiDout;
      spiSclk <= 1'h1;
      repeat (4) @(posedge ref_clk);
      spiSclk <= 1'h0;
    end
    repeat (4) @(posedge ref_clk);
    spiCsN <= 1'h1;
    // released data line must not keep its last value
    spiDin <= ~tx[0];
    repeat (8) @(posedge ref_clk);
  endtask : xfer
endmodule : utci_host_model

// file: dv/utci_uart_ctrl_tb_top.sv
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin nErrors++; \
  $display("Error %s exp %0h got %0h", n, e, s); end end

module utci_uart_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BITC = 20;
  logic ref_clk;
  logic rst_n;
  logic rxd;
  logic shutdownN;
  logic spiCsN;
  logic spiSclk;
  logic spiDin;
  logic spiDout;
  logic txd;
  logic rtsN;
  logic irqN;
  int   nErrors;
  int   checked;

  utci_uart_ctrl #(.BIT_CYCLES(BITC), .FIFO_DEPTH(8)) i_utci_uart_ctrl (
    .ref_clk(ref_clk), .rst_n(rst_n), .spiCsN(spiCsN), .spiSclk(spiSclk),
    .spiDin(spiDin), .spiDout(spiDout), .rxd(rxd), .txd(txd), .rtsN(rtsN),
    .shutdownN(shutdownN), .irqN(irqN));
  utci_host_model i_utci_host_model (
    .ref_clk(ref_clk), .spiCsN(spiCsN), .spiSclk(spiSclk), .spiDin(spiDin),
    .spiDout(spiDout));

  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic rdData(output logic [15:0] r);
    i_utci_host_model.xfer({utci_pkg::CMD_RD_DATA, 14'h0000}, r);
  endtask : rdData

  task automatic rdCfg(output logic [15:0] r);
    i_utci_host_model.xfer({utci_pkg::CMD_RD_CFG, 14'h0000}, r);
  endtask : rdCfg

  task automatic wrCfg(input logic [3:0] m, input logic st, input logic pe);
    logic [15:0] w;
    logic [15:0] r;
    w = {utci_pkg::CMD_WR_CFG, m, 10'h000};
    w[utci_pkg::POS_TWO_STOP] = st;
    w[utci_pkg::POS_EXTRA_EN] = pe;
    i_utci_host_model.xfer(w, r);
  endtask : wrCfg

  task automatic wrData(input logic inh, input logic rts, input logic [8:0] d);
    logic [15:0] r;
    i_utci_host_model.xfer({utci_pkg::CMD_WR_DATA, 3'h0, inh, rts, d}, r);
  endtask : wrData

  // a stop of one leaves the line high, so chars can follow back to back
  task automatic sendRx(input logic [8:0] d, input logic nine, input logic stp);
    rxd <= 1'h0;
    repeat (BITC) @(posedge ref_clk);
    for (int i = 0; i < 9; i++) begin
      if (i < 8 || nine) begin
        rxd <= d[i];
        repeat (BITC) @(posedge ref_clk);
      end
    end
    rxd <= stp;
    repeat (BITC) @(posedge ref_clk);
    if (!stp) begin
      rxd <= 1'h1;
      repeat (2 * BITC) @(posedge ref_clk);
    end
  endtask : sendRx

  // samples start, data and extra bit mid-bit; returns idle wait before start
  task automatic txChar(output logic [9:0] b, output int t);
    t = 0;
    while (txd === 1'h1 && t < 4000) begin
      @(posedge ref_clk);
      t++;
    end
    repeat (BITC / 2) @(posedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      b[i] = txd;
      repeat (BITC) @(posedge ref_clk);
    end
  endtask : txChar

  task automatic tReset();
    logic [15:0] r;
    rdCfg(r);
    `CHK("masks", 4'h0, r[13:10])
    `CHK("twoStop", 1'h0, r[utci_pkg::POS_TWO_STOP])
    `CHK("txEmpty", 1'h1, r[utci_pkg::POS_TX_EMPTY])
    `CHK("irqN", 1'h1, irqN)
  endtask : tReset

  task automatic tFrame();
    logic [15:0] r;
    logic [9:0]  b1;
    logic [9:0]  b2;
    int          t1;
    int          t2;
    int          gap;
    for (int st = 0; st < 2; st++) begin
      wrCfg(4'h0, st[0], 1'h1);
      rdCfg(r);
      `CHK("twoStop", st[0], r[utci_pkg::POS_TWO_STOP])
      fork
        begin
          wrData(1'h0, 1'h0, 9'h1A5);
          wrData(1'h0, 1'h0, 9'h03C);
        end
        begin
          txChar(b1, t1);
          txChar(b2, t2);
        end
      join
      gap = (st + 1) * BITC - BITC / 2;
      `CHK("char1", {1'h1, 8'hA5, 1'h0}, b1)
      `CHK("char2", {1'h0, 8'h3C, 1'h0}, b2)
      `CHK("stopGap", 1'h1, (t2 >= gap - 2 && t2 <= gap + 2))
    end
  endtask : tFrame

  task automatic tInhibit();
    logic [15:0] r;
    int          n;
    n = 0;
    wrData(1'h1, 1'h1, 9'h0FF);
    `CHK("rtsN", 1'h0, rtsN)
    repeat (4 * BITC) begin
      if (txd !== 1'h1) n++;
      @(posedge ref_clk);
    end
    `CHK("txIdle", 0, n)
    rdCfg(r);
    `CHK("txEmpty", 1'h1, r[utci_pkg::POS_TX_EMPTY])
    wrData(1'h1, 1'h0, 9'h0FF);
    `CHK("rtsN", 1'h1, rtsN)
  endtask : tInhibit

  task automatic tTxIrq();
    logic [15:0] r;
    wrCfg(4'h8, 1'h0, 1'h0);
    wrData(1'h0, 1'h0, 9'h055);
    repeat (12 * BITC) @(posedge ref_clk);
    `CHK("irqN", 1'h0, irqN)
    rdData(r);
    `CHK("irqN", 1'h1, irqN)
    rdCfg(r);
    `CHK("txEmpty", 1'h1, r[utci_pkg::POS_TX_EMPTY])
    `CHK("irqN", 1'h1, irqN)
  endtask : tTxIrq

  task automatic tRx();
    logic [15:0] r;
    wrCfg(4'h2, 1'h0, 1'h1);
    sendRx(9'h196, 1'h1, 1'h1);
    `CHK("irqN", 1'h0, irqN)
    rdData(r);
    `CHK("rxWord", 9'h196, r[8:0])
    `CHK("irqN", 1'h1, irqN)
    wrCfg(4'h4, 1'h1, 1'h1);
    sendRx(9'h13C, 1'h1, 1'h1);
    sendRx(9'h0C3, 1'h1, 1'h1);
    repeat (BITC) @(posedge ref_clk);
    `CHK("irqN", 1'h0, irqN)
    rdData(r);
    `CHK("rxWord", 9'h13C, r[8:0])
    rdData(r);
    `CHK("rxWord", 9'h0C3, r[8:0])
    rdCfg(r);
    `CHK("rxAvail", 1'h0, r[utci_pkg::POS_RX_AVAIL])
    `CHK("irqN", 1'h1, irqN)
  endtask : tRx

  task automatic tFrameErr();
    logic [15:0] r;
    wrCfg(4'h1, 1'h0, 1'h0);
    sendRx(9'h0AA, 1'h0, 1'h0);
    `CHK("irqN", 1'h0, irqN)
    rdData(r);
    `CHK("frameErr", 1'h1, r[utci_pkg::POS_ACTIVITY])
    sendRx(9'h011, 1'h0, 1'h1);
    repeat (BITC) @(posedge ref_clk);
    rdData(r);
    if (r[7:0] === 8'hAA) rdData(r);
    `CHK("rxWord", 8'h11, r[7:0])
    `CHK("frameErr", 1'h0, r[utci_pkg::POS_ACTIVITY])
  endtask : tFrameErr

  task automatic tShutdown();
    shutdownN <= 1'h0;
    repeat (8) @(posedge ref_clk);
    rxd <= 1'h0;
    repeat (BITC) @(posedge ref_clk);
    rxd <= 1'h1;
    repeat (BITC) @(posedge ref_clk);
    `CHK("irqN", 1'h0, irqN)
    shutdownN <= 1'h1;
    repeat (8) @(posedge ref_clk);
    `CHK("irqN", 1'h1, irqN)
  endtask : tShutdown

  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, nErrors);
    if (nErrors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  initial begin
    rst_n     = 1'h0;
    rxd       = 1'h1;
    shutdownN = 1'h1;
    nErrors   = 0;
    checked   = 0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge ref_clk);
    tReset();
    tFrame();
    tInhibit();
    tTxIrq();
    tRx();
    tFrameErr();
    tShutdown();
    give_verdict();
  end

  // whole run needs well under 20000 cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    nErrors++;
    give_verdict();
  end
endmodule : utci_uart_ctrl_tb_top
